// ==== rtl/hsc_pkg.sv ====
/*
  Shared constants and types for the high-speed pulse counter: register
  offsets, control and status field positions, reset values, the counting
  mode enumeration and the scan timing.
  Assumes a 40 MHz system clock and a 32-bit register port.
*/
package hsc_pkg;

  typedef logic [31:0] data_t;
  typedef logic [7:0] addr_t;

  typedef enum logic [1:0] {
    MODE_ADD,
    MODE_UPDOWN,
    MODE_TWO_2EDGE,
    MODE_TWO_4EDGE
  } mode_e;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses, one word each)
  localparam addr_t CTRL_OFS = 8'h00;
  localparam addr_t STATUS_OFS = 8'h04;
  localparam addr_t CURRENT_OFS = 8'h08;
  localparam addr_t PRESET_ONE_OFS = 8'h0c;
  localparam addr_t PRESET_TWO_OFS = 8'h10;
  localparam addr_t RELOAD_OFS = 8'h14;
  localparam addr_t ACTIVE_PRESET_OFS = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // Control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_KEEP_BIT = 2;
  localparam int CTRL_TWO_PRESET_BIT = 3;
  localparam int CTRL_CLEAR_ON_TWO_BIT = 4;
  localparam int CTRL_GATE_BIT = 5;
  localparam int CTRL_CMP_CLEAR_BIT = 6;
  localparam int CTRL_RST_EN_BIT = 7;
  localparam int CTRL_W = 8;

  // Status field positions
  localparam int ST_CMP_ONE_BIT = 0;
  localparam int ST_CMP_TWO_BIT = 1;
  localparam int ST_MATCH_BIT = 2;
  localparam int ST_RESET_DONE_BIT = 3;
  localparam int ST_OVERFLOW_BIT = 4;
  localparam int ST_UNDERFLOW_BIT = 5;
  localparam int ST_DIR_BIT = 6;
  localparam int ST_COUNTING_BIT = 7;

  // Values after reset, and the counter maximum
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  localparam data_t VALUE_RESET = 32'h0000_0000;
  localparam data_t VALUE_MAX = 32'hffff_ffff;

  ////////////////////////////////////////////////////////////////////////////
  // Scan timing
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned SCAN_TIME_US = 1000;
  localparam int unsigned SCAN_CYCLES_DEF = SCAN_TIME_US * CLK_MHZ;

endpackage

// ==== rtl/hsc_count_if.sv ====
/*
  Link between the pin edge decoder and the counter core.
  Assumes both ends run on clk_sys.
*/
`timescale 1ns/10ps
interface hsc_count_if;
  import hsc_pkg::*;
  mode_e mode;
  logic step_up;
  logic step_down;
  logic select_level;
  logic reset_rise;

  modport decoder (input mode, output step_up, output step_down, output select_level, output reset_rise);
  modport core (output mode, input step_up, input step_down, input select_level, input reset_rise);
endinterface

// ==== rtl/hsc_edge_decoder.sv ====
/*
  Synchronises the three counter pins and turns their edges into
  one-cycle up and down steps for the selected counting mode.
  Assumes asynchronous pins and a clock far faster than the pulse rate.
*/
`timescale 1ns/10ps
module hsc_edge_decoder (
  input wire logic clk_sys,              // System clock
  input wire logic sys_rst,              // Synchronous reset, active high
  input wire logic pulse_input_pin,      // Pulse input, phase A in two-phase modes
  input wire logic up_down_select_pin,   // Up/down select, phase B in two-phase modes
  input wire logic reset_input_pin,      // Counter reset input
  hsc_count_if.decoder link              // Steps toward the core
);
  import hsc_pkg::*;

  logic [2:0] meta;
  logic [2:0] sync;
  logic [2:0] last;
  logic a;
  logic b;
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers; only sync and last feed logic
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta <= 3'h0;
      sync <= 3'h0;
      last <= 3'h0;
    end else begin
      meta <= {reset_input_pin, up_down_select_pin, pulse_input_pin};
      sync <= meta;
      last <= sync;
    end
  end

  assign a = sync[0];
  assign b = sync[1];
  assign a_rise = a & ~last[0];
  assign a_fall = ~a & last[0];
  assign b_rise = b & ~last[1];
  assign b_fall = ~b & last[1];
  assign link.select_level = b;
  assign link.reset_rise = sync[2] & ~last[2];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    link.step_up = 1'b0;
    link.step_down = 1'b0;
    case (link.mode)
      MODE_ADD: begin
        link.step_up = a_rise;
      end
      MODE_UPDOWN: begin
        link.step_up = a_rise & b;
        link.step_down = a_rise & ~b;
      end
      MODE_TWO_2EDGE: begin
        link.step_up = (a_rise & ~b) | (a_fall & b);
        link.step_down = (a_rise & b) | (a_fall & ~b);
      end
      default: begin
        link.step_up = (a_rise & ~b) | (a_fall & b) | (b_rise & a) | (b_fall & ~a);
        link.step_down = (a_rise & b) | (a_fall & ~b) | (b_rise & ~a) | (b_fall & a);
      end
    endcase
  end

endmodule

// ==== rtl/high_speed_pulse_counter.sv ====
/*
  32-bit high-speed pulse counter for one input group: single-phase adding,
  up/down selected reversible, or two-phase quadrature in 2-edge or 4-edge
  mode, with preset compare, second preset, clear on match and wrap flags.
  Assumes a 40 MHz clock, a same-clock register master that never waits,
  and run_mode / program_load driven by same-clock controller logic.
*/
// Added by the designer: strobed register access and the address map.
// Notes on behaviour
// - Readable direction flag, set means adding.
// - Adding mode keeps flag at adding.
// - Up/down mode flag follows select pin.
// - Two-phase flag changes on match or wrap.
// - Two-phase flag starts adding, shows last compare.
// - Reset input loads reload value, one-scan pulse.
// - Count only while gate bit is set.
// - Up/down counts, value shown once per scan.
// - Preset one match sets outputs, optional keep.
// - Compare output latched until clear; pulse one scan.
// - Count needs running and gate both on.
// - Program load stops counting until run again.
// - A leading B up, B leading A down.
// - Two presets: match loads preset two.
// - Preset two match sets output two, clears.
// - Up past maximum wraps to zero, pulses.
// - Down below zero wraps to maximum, pulses.
`timescale 1ns/10ps
module high_speed_pulse_counter #(
  parameter int unsigned SCAN_CYCLES = hsc_pkg::SCAN_CYCLES_DEF
) (
  input wire logic clk_sys,                    // System clock, 40 MHz
  input wire logic sys_rst,                    // Synchronous reset, active high
  input wire logic pulse_input_pin,            // Pulse or phase A pin
  input wire logic up_down_select_pin,         // Up/down select or phase B pin
  input wire logic reset_input_pin,            // Counter reset pin
  input wire logic run_mode,                   // Controller running, level
  input wire logic program_load,               // Program download, one-cycle pulse
  input wire hsc_pkg::addr_t reg_addr,         // Register byte address
  input wire hsc_pkg::data_t reg_wdata,        // Register write data
  input wire logic reg_wr,                     // Write strobe
  input wire logic reg_rd,                     // Read strobe
  output hsc_pkg::data_t reg_rdata,            // Read data, cycle after strobe
  output logic compare_output_one,             // Latched preset one compare output
  output logic compare_output_two,             // Latched preset two compare output
  output logic compare_match_pulse,            // Match status, one scan
  output logic reset_done_pulse,               // Reset status, one scan
  output logic overflow_pulse,                 // Overflow status, one scan
  output logic underflow_pulse,                // Underflow status, one scan
  output logic direction_flag_group_one,       // Count direction, high is adding
  output logic counting_active                 // Counter is enabled
);
  import hsc_pkg::*;

  initial begin
    if (SCAN_CYCLES < 2) begin
      $error("SCAN_CYCLES must be at least 2");
    end
  end

  hsc_count_if link ();

  hsc_edge_decoder u_decoder (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pulse_input_pin(pulse_input_pin),
    .up_down_select_pin(up_down_select_pin),
    .reset_input_pin(reset_input_pin),
    .link(link)
  );

  logic [CTRL_W-1:0] ctrl;
  data_t preset_one;
  data_t preset_two;
  data_t reload_value;
  data_t active_preset;
  data_t count_raw;
  data_t current_value;
  logic second_stage;
  logic keep_hold;
  logic run_last;
  logic load_halt;
  logic [31:0] scan_cnt;
  logic scan_tick;
  logic [3:0] pend;
  mode_e mode;
  logic two_phase;
  logic gate;
  logic reset_load;
  logic step;
  logic wrap_up;
  logic wrap_down;
  data_t next_count;
  logic match;
  logic match_one;
  logic match_two;

  assign mode = mode_e'(ctrl[CTRL_MODE_LSB +: 2]);
  assign link.mode = mode;
  assign two_phase = (mode == MODE_TWO_2EDGE) || (mode == MODE_TWO_4EDGE);
  assign gate = ctrl[CTRL_GATE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Scan tick divider; all status pulses and the visible value step on it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      scan_cnt <= 32'h0000_0000;
    end else if (scan_cnt == SCAN_CYCLES - 1) begin
      scan_cnt <= 32'h0000_0000;
    end else begin
      scan_cnt <= scan_cnt + 32'h0000_0001;
    end
  end

  assign scan_tick = (scan_cnt == SCAN_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Run and download handling
  // download halts until run rises
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      run_last <= 1'b0;
      load_halt <= 1'b0;
    end else begin
      run_last <= run_mode;
      if (program_load) begin
        load_halt <= 1'b1;
      end else if (run_mode & ~run_last) begin
        load_halt <= 1'b0;
      end
    end
  end

  assign counting_active = run_mode & gate & ~load_halt;

  ////////////////////////////////////////////////////////////////////////////
  // Step arithmetic
  assign reset_load = link.reset_rise & ctrl[CTRL_RST_EN_BIT];
  assign step = counting_active & ~keep_hold & (link.step_up | link.step_down);
  assign wrap_up = step & link.step_up & (count_raw == VALUE_MAX);
  assign wrap_down = step & link.step_down & (count_raw == VALUE_RESET);

  always_comb begin
    next_count = count_raw;
    if (step && link.step_up) begin
      next_count = count_raw + 32'h0000_0001;
    end else if (step && link.step_down) begin
      next_count = count_raw - 32'h0000_0001;
    end
  end

  assign match = step & ~reset_load & (next_count == active_preset);
  assign match_one = match & ~second_stage;
  assign match_two = match & second_stage;

  ////////////////////////////////////////////////////////////////////////////
  // Count register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count_raw <= VALUE_RESET;
    end else if (reset_load) begin
      count_raw <= reload_value;
    end else if (match_two && ctrl[CTRL_CLEAR_ON_TWO_BIT]) begin
      count_raw <= VALUE_RESET;
    end else begin
      count_raw <= next_count;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      current_value <= VALUE_RESET;
    end else if (scan_tick) begin
      current_value <= count_raw;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Preset staging and keep
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      second_stage <= 1'b0;
      active_preset <= VALUE_RESET;
    end else if (reset_load) begin
      second_stage <= 1'b0;
      active_preset <= preset_one;
    end else if (match_one && ctrl[CTRL_TWO_PRESET_BIT]) begin
      second_stage <= 1'b1;
      active_preset <= preset_two;
    end else if (reg_wr && reg_addr == PRESET_ONE_OFS && !second_stage) begin
      active_preset <= reg_wdata;
    end else if (reg_wr && reg_addr == PRESET_TWO_OFS && second_stage) begin
      active_preset <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      keep_hold <= 1'b0;
    end else if (match_one && ctrl[CTRL_KEEP_BIT] && !ctrl[CTRL_TWO_PRESET_BIT]) begin
      keep_hold <= 1'b1;
    end else if (reset_load || ctrl[CTRL_CMP_CLEAR_BIT]) begin
      keep_hold <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched compare outputs; a match wins over a clear in the same cycle
  // match sets output one
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      compare_output_one <= 1'b0;
      compare_output_two <= 1'b0;
    end else begin
      if (match_one) begin
        compare_output_one <= 1'b1;
      end else if (ctrl[CTRL_CMP_CLEAR_BIT]) begin
        compare_output_one <= 1'b0;
      end
      if (match_two) begin
        compare_output_two <= 1'b1;
      end else if (ctrl[CTRL_CMP_CLEAR_BIT]) begin
        compare_output_two <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-scan status pulses: events gather until a tick, then show a scan
  // match pulse lasts one scan
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pend <= 4'h0;
      compare_match_pulse <= 1'b0;
      reset_done_pulse <= 1'b0;
      overflow_pulse <= 1'b0;
      underflow_pulse <= 1'b0;
    end else if (scan_tick) begin
      compare_match_pulse <= pend[0];
      reset_done_pulse <= pend[1];
      overflow_pulse <= pend[2];
      underflow_pulse <= pend[3];
      pend <= {wrap_down, wrap_up, reset_load, match};
    end else begin
      pend <= pend | {wrap_down, wrap_up, reset_load, match};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count direction flag
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      direction_flag_group_one <= 1'b1;
    end else begin
      case (mode)
        MODE_ADD: begin
          direction_flag_group_one <= 1'b1;
        end
        MODE_UPDOWN: begin
          direction_flag_group_one <= link.select_level;
        end
        default: begin
          if (wrap_up || wrap_down || match) begin
            direction_flag_group_one <= link.step_up;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl <= CTRL_RESET;
      preset_one <= VALUE_RESET;
      preset_two <= VALUE_RESET;
      reload_value <= VALUE_RESET;
    end else if (reg_wr) begin
      if (reg_addr == CTRL_OFS) begin
        ctrl <= reg_wdata[CTRL_W-1:0];
      end else if (reg_addr == PRESET_ONE_OFS) begin
        preset_one <= reg_wdata;
      end else if (reg_addr == PRESET_TWO_OFS) begin
        preset_two <= reg_wdata;
      end else if (reg_addr == RELOAD_OFS) begin
        reload_value <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads; data stand only in the cycle after the strobe
  // direction flag readable
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= VALUE_RESET;
    end else if (!reg_rd) begin
      reg_rdata <= VALUE_RESET;
    end else if (reg_addr == CTRL_OFS) begin
      reg_rdata <= {{(32 - CTRL_W){1'b0}}, ctrl};
    end else if (reg_addr == STATUS_OFS) begin
      reg_rdata <= {24'h000000, counting_active, direction_flag_group_one, underflow_pulse,
                    overflow_pulse, reset_done_pulse, compare_match_pulse, compare_output_two,
                    compare_output_one};
    end else if (reg_addr == CURRENT_OFS) begin
      reg_rdata <= current_value;
    end else if (reg_addr == PRESET_ONE_OFS) begin
      reg_rdata <= preset_one;
    end else if (reg_addr == PRESET_TWO_OFS) begin
      reg_rdata <= preset_two;
    end else if (reg_addr == RELOAD_OFS) begin
      reg_rdata <= reload_value;
    end else if (reg_addr == ACTIVE_PRESET_OFS) begin
      reg_rdata <= active_preset;
    end else begin
      reg_rdata <= VALUE_RESET;
    end
  end

endmodule

// ==== verif/hsc_properties.sv ====
/*
  Port-level checks for the high-speed pulse counter.
  Assumes one clock, clk_sys, and a synchronous active-high sys_rst.
*/
`timescale 1ns/10ps
module hsc_properties #(
  parameter int unsigned SCAN_CYCLES = 8
) (
  input wire logic clk_sys,                   // Clock
  input wire logic sys_rst,                   // Reset
  input wire logic up_down_select_pin,        // Select or phase B
  input wire logic run_mode,                  // Controller running
  input wire logic program_load,              // Download pulse
  input wire hsc_pkg::addr_t reg_addr,        // Register address
  input wire hsc_pkg::data_t reg_wdata,       // Write data
  input wire logic reg_wr,                    // Write strobe
  input wire logic reg_rd,                    // Read strobe
  input wire hsc_pkg::data_t reg_rdata,       // Read data
  input wire logic compare_output_one,        // Latched compare one
  input wire logic compare_output_two,        // Latched compare two
  input wire logic compare_match_pulse,       // Match pulse
  input wire logic reset_done_pulse,          // Reset pulse
  input wire logic overflow_pulse,            // Overflow pulse
  input wire logic underflow_pulse,           // Underflow pulse
  input wire logic direction_flag_group_one,  // Direction flag
  input wire logic counting_active            // Counter enabled
);
  import hsc_pkg::*;
  logic [7:0] ctl;
  int unsigned match_len;
  int unsigned rdone_len;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////
  // Mode and gate are not ports, so mirror the control word
  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      ctl <= 8'h00;
    else if (reg_wr && reg_addr == CTRL_OFS)
      ctl <= reg_wdata[7:0];
  end
  always_ff @(posedge clk_sys) begin
    match_len <= compare_match_pulse ? match_len + 1 : 0;
  end
  always_ff @(posedge clk_sys) begin
    rdone_len <= reset_done_pulse ? rdone_len + 1 : 0;
  end

  chk_dir_init_add: assert property ($past(sys_rst) |-> direction_flag_group_one)
    else $error("direction flag not adding after reset");
  chk_dir_add_mode: assert property ((ctl[1:0] == 2'd0) [*3] |-> direction_flag_group_one)
    else $error("direction flag not adding in adding mode");
  chk_dir_follows_sel: assert property (
    $changed(up_down_select_pin) && ctl[1:0] == 2'd1 ##1 (ctl[1:0] == 2'd1 && $stable(up_down_select_pin)) [*5]
    |-> direction_flag_group_one == up_down_select_pin)
    else $error("direction flag does not follow select pin");
  chk_match_one_scan: assert property ($fell(compare_match_pulse) |-> match_len == SCAN_CYCLES)
    else $error("match pulse length is not one scan");
  chk_reset_one_scan: assert property ($fell(reset_done_pulse) |-> rdone_len == SCAN_CYCLES)
    else $error("reset status length is not one scan");
  chk_cmp_one_hold: assert property (compare_output_one && !ctl[6] |=> compare_output_one)
    else $error("compare output one dropped without clear");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  chk_gate_off_idle: assert property (!(run_mode && ctl[5]) |-> !counting_active)
    else $error("counting without run and gate");
  chk_load_halts: assert property (program_load |=> !counting_active)
    else $error("counting right after program load");
  chk_run_starts: assert property (
    $rose(run_mode) && ctl[5] && !reg_wr && !program_load ##1 run_mode |-> counting_active)
    else $error("no counting after stop to run with gate on");

  cover property (compare_output_two);
  cover property ($rose(underflow_pulse));
  cover property ($rose(overflow_pulse));
endmodule

// ==== verif/hsc_encoder_model.sv ====
/*
  Encoder and sensor model driving the counter pins.
  Assumes edges at least four clocks apart, which the decoder needs.
*/
`timescale 1ns/10ps
module hsc_encoder_model (
  input wire logic clk_sys,  // Clock the edges are paced on
  output logic phase_a,      // Pulse or phase A
  output logic phase_b,      // Select or phase B
  output logic rst_pin       // Reset input
);
  int hold = 3;
  initial begin
    phase_a = 1'b0;
    phase_b = 1'b0;
    rst_pin = 1'b0;
  end

  ////////////////////////////////////////////////////////////
  // Every level change is followed by a quiet time of hold clocks
  task automatic put(input logic a, input logic b, input logic r);
    @(posedge clk_sys);
    phase_a <= a;
    phase_b <= b;
    rst_pin <= r;
    repeat (hold) @(posedge clk_sys);
  endtask
  task automatic sel(input logic v);
    put(phase_a, v, 1'b0);
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      put(1'b1, phase_b, 1'b0);
      put(1'b0, phase_b, 1'b0);
    end
  endtask
  // Forward means phase A leads phase B
  task automatic quad(input int n, input logic fwd);
    repeat (n) begin
      put(fwd, ~fwd, 1'b0);
      put(1'b1, 1'b1, 1'b0);
      put(~fwd, fwd, 1'b0);
      put(1'b0, 1'b0, 1'b0);
    end
  endtask
  // A slow reset press, longer than a pin edge
  task automatic rst_pulse;
    put(phase_a, phase_b, ~rst_pin);
    repeat (5) @(posedge clk_sys);
    put(phase_a, phase_b, ~rst_pin);
  endtask
endmodule

// ==== verif/tb_top.sv ====
/*
  Self-checking bench for the pulse counter with a behavioural count model.
  Assumes the design package and the encoder model are compiled first.
*/
`timescale 1ns/10ps
module tb_top;
  import hsc_pkg::*;
  localparam int unsigned SCAN = 8;
  logic clk_sys, sys_rst, run_mode, program_load, reg_wr, reg_rd;
  logic a_pin, b_pin, r_pin, cmp1, cmp2, mpulse, rdone, ovf, unf, dir, active;
  addr_t reg_addr;
  data_t reg_wdata, reg_rdata, rv;
  logic [3:0] seen;
  int bad_count, checks, cycles, seed, n;
  longint m_val;

  high_speed_pulse_counter #(.SCAN_CYCLES(SCAN)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .pulse_input_pin(a_pin), .up_down_select_pin(b_pin), .reset_input_pin(r_pin), .run_mode(run_mode),
    .program_load(program_load), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .compare_output_one(cmp1), .compare_output_two(cmp2),
    .compare_match_pulse(mpulse), .reset_done_pulse(rdone), .overflow_pulse(ovf),
    .underflow_pulse(unf), .direction_flag_group_one(dir), .counting_active(active));
  hsc_encoder_model i_enc (.clk_sys(clk_sys), .phase_a(a_pin), .phase_b(b_pin), .rst_pin(r_pin));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Sticky record of one-scan pulses, cleared by the bench off the edge
  always @(posedge clk_sys) begin
    seen <= seen | {ovf, unf, rdone, mpulse};
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish;
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input data_t exp, input data_t got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input addr_t a, input data_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input addr_t a, input data_t exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(what, exp, reg_rdata);
  endtask
  // The current value register refreshes once a scan, so let three pass
  task automatic cur_chk(input string what);
    repeat (3 * SCAN) @(posedge clk_sys);
    rd_chk(what, CURRENT_OFS, data_t'(m_val));
  endtask
  task automatic reload(input data_t v);
    wr(RELOAD_OFS, v);
    @(negedge clk_sys);
    seen = 4'h0;
    i_enc.rst_pulse;
    m_val = v;
    cur_chk("reset load");
    chk("reset status", 32'h1, data_t'(seen[1]));
  endtask
  function automatic data_t cw(input mode_e m, input logic [5:0] f);
    return {24'h0, f, m};
  endfunction

  initial begin
    sys_rst = 1'b1;
    run_mode = 1'b1;
    program_load = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    seen = 4'h0;
    bad_count = 0;
    checks = 0;
    cycles = 0;
    seed = 91;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd_chk("status", STATUS_OFS, 32'h40);
    rd_chk("unmapped", {3'h7, 5'($random(seed))}, 32'h0);
    wr(CURRENT_OFS, 32'h5);
    rd_chk("current read only", CURRENT_OFS, 32'h0);
    rv = $random(seed);
    wr(PRESET_ONE_OFS, rv ^ 32'h8000_0000);
    wr(CTRL_OFS, cw(MODE_UPDOWN, 6'h28));
    reload(rv);
    for (int d = 0; d < 2; d++) begin
      i_enc.sel(d[0]);
      n = 1 + ($unsigned($random(seed)) % 6);
      i_enc.pulses(n);
      m_val += d ? n : -n;
      cur_chk("updown count");
      chk("dir updown", data_t'(d), data_t'(dir));
    end
    i_enc.sel(1'b0);
    wr(CTRL_OFS, cw(MODE_UPDOWN, 6'h20));
    i_enc.pulses(3);
    cur_chk("gate off");
    wr(CTRL_OFS, cw(MODE_ADD, 6'h28));
    i_enc.pulses(2);
    m_val += 2;
    cur_chk("add count");
    chk("dir add", 32'h1, data_t'(dir));
    wr(CTRL_OFS, cw(MODE_UPDOWN, 6'h28));
    reload(32'h0);
    i_enc.pulses(1);
    m_val -= 1;
    cur_chk("underflow wrap");
    chk("underflow flag", 32'h1, data_t'(seen[2]));
    i_enc.sel(1'b1);
    i_enc.pulses(1);
    m_val += 1;
    cur_chk("overflow wrap");
    chk("overflow flag", 32'h1, data_t'(seen[3]));
    wr(PRESET_ONE_OFS, 32'h3);
    wr(CTRL_OFS, cw(MODE_UPDOWN, 6'h09));
    i_enc.pulses(5);
    m_val = 3;
    cur_chk("keep at preset");
    chk("match flags", 32'h3, data_t'({cmp1, seen[0]}));
    wr(PRESET_ONE_OFS, 32'h4);
    wr(CTRL_OFS, cw(MODE_UPDOWN, 6'h10));
    repeat (4) @(negedge clk_sys);
    chk("compare clear", 32'h0, data_t'(cmp1));
    // Park phase B low while the gate is off so the first quadrature step is a single edge
    i_enc.sel(1'b0);
    wr(PRESET_TWO_OFS, 32'h8);
    wr(CTRL_OFS, cw(MODE_TWO_4EDGE, 6'h2e));
    reload(32'h0);
    i_enc.quad(1, 1'b1);
    m_val = 4;
    cur_chk("quad up");
    rd_chk("active preset", ACTIVE_PRESET_OFS, 32'h8);
    i_enc.quad(1, 1'b1);
    m_val = 0;
    cur_chk("clear on two");
    chk("cmp two", 32'h1, data_t'(cmp2));
    chk("dir up match", 32'h1, data_t'(dir));
    i_enc.quad(1, 1'b0);
    m_val = -4;
    cur_chk("quad down");
    chk("dir underflow", 32'h0, data_t'(dir));
    wr(CTRL_OFS, cw(MODE_TWO_2EDGE, 6'h28));
    reload(32'h10);
    i_enc.quad(1, 1'b1);
    m_val += 2;
    cur_chk("two edge");
    chk("dir previous", 32'h0, data_t'(dir));
    @(posedge clk_sys);
    program_load <= ~program_load;
    @(posedge clk_sys);
    program_load <= ~program_load;
    i_enc.quad(1, 1'b1);
    cur_chk("halted by load");
    @(posedge clk_sys);
    run_mode <= 1'b0;
    repeat (2) @(posedge clk_sys);
    run_mode <= 1'b1;
    i_enc.quad(1, 1'b1);
    m_val += 2;
    cur_chk("resumed on run");
    tally_and_finish;
  end
endmodule

bind high_speed_pulse_counter hsc_properties #(.SCAN_CYCLES(SCAN_CYCLES)) i_props (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .up_down_select_pin(up_down_select_pin), .run_mode(run_mode),
  .program_load(program_load), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .compare_output_one(compare_output_one),
  .compare_output_two(compare_output_two), .compare_match_pulse(compare_match_pulse),
  .reset_done_pulse(reset_done_pulse), .overflow_pulse(overflow_pulse), .underflow_pulse(underflow_pulse),
  .direction_flag_group_one(direction_flag_group_one), .counting_active(counting_active));
